// ==== usb_device_ctrl_config_tb_top.sv ====
// Testbench: controller and device joined, user sides driven
`timescale 1ns/100ps
`default_nettype none
module usb_device_ctrl_config_tb_top;
  logic                          clk = 1'b0;
  logic                          resetn = 1'b0;
  logic [7:0]                    addr = 8'h00;
  logic [7:0]                    wdata = 8'h00;
  logic                          wr = 1'b0;
  logic                          rd = 1'b0;
  logic [7:0]                    rdata;
  logic                          irq, wake;
  logic                          suspend = 1'b0;
  logic                          pll_rst = 1'b1;
  logic                          dev_rst = 1'b0;
  logic [3:0]                    req_seen = 4'h0;
  logic [1:0]                    cur_if = 2'h0;
  logic                          cur_alt = 1'b0;
  logic [2:0]                    cur_ep = 3'h0;
  logic [7:0]                    bus_event = 8'h00;
  logic                          pin_sel, out_g, in_g, reg_pd, phy_powerdown_signal;
  logic                          pll_pd, en, resume, stall, clk_gate, done;
  usbdc_pkg::usbdc_epcfg_s [3:0] ep_cfg;
  logic [3:0][1:0]               out_type;
  logic [7:0]                    v;
  int                            err_count = 0;
  int                            samples_checked = 0;
  always #10 clk = ~clk;
  usbdc_if usbdc_if_inst (.i_clk(clk));
  usbdc_device usbdc_device_inst (
    .i_clk(clk), .i_resetn(resetn), .bus(usbdc_if_inst.dev),
    .i_suspend(suspend), .i_pll_rst(pll_rst), .i_dev_rst(dev_rst),
    .i_req_seen(req_seen), .i_cur_if(cur_if), .i_cur_alt(cur_alt),
    .i_cur_ep(cur_ep), .i_bus_event(bus_event),
    .o_usb_pin_select(pin_sel), .o_out_buffer_guard(out_g),
    .o_in_buffer_guard(in_g), .o_regulator_powerdown(reg_pd),
    .o_phy_powerdown_signal(phy_powerdown_signal), .o_pll_powerdown(pll_pd),
    .o_controller_enable(en), .o_resume_signal(resume),
    .o_ep0_stall(stall), .o_fullspeed_clock_gate(clk_gate),
    .o_ep_cfg(ep_cfg), .o_ep_out_type(out_type), .o_cfg_load_done(done));
  usbdc_host usbdc_host_inst (
    .i_clk(clk), .i_resetn(resetn), .bus(usbdc_if_inst.ctl),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq(irq), .o_wake(wake));
  usbdc_props usbdc_props_inst (
    .i_clk(clk), .i_resetn(resetn), .addr(usbdc_if_inst.addr),
    .wdata(usbdc_if_inst.wdata), .wr(usbdc_if_inst.wr),
    .rd(usbdc_if_inst.rd), .rdata(usbdc_if_inst.rdata),
    .irq(usbdc_if_inst.irq), .wake(usbdc_if_inst.wake));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Poll controller status until not busy
  task automatic idle;
    int n;
    n = 0;
    do begin
      get(usbdc_pkg::H_STAT, v);
      n++;
    end while (v[0] !== 1'b0 && n < 2000);
    check(v & 8'h01, 8'h00);
  endtask
  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    cmd(usbdc_pkg::H_ADDR, a);
    cmd(usbdc_pkg::H_DATA, d);
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    cmd(usbdc_pkg::H_ADDR, a);
    cmd(usbdc_pkg::H_CMD, 8'h08);
    idle;
    get(usbdc_pkg::H_RDBK, v);
    check(v, e);
  endtask
  task automatic t_reset;
    rr(usbdc_pkg::ADDR_PINPWR, 8'h80);
    rr(usbdc_pkg::ADDR_IRQEN, usbdc_pkg::RST_IRQEN);
    rr(usbdc_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk) {pll_rst, dev_rst} <= 2'h1;
    rr(usbdc_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk) dev_rst <= 1'b0;
    rr(usbdc_pkg::ADDR_CTRL, 8'h02);
    rr(8'hb8, 8'h00);
  endtask
  task automatic t_pinpwr;
    rw(usbdc_pkg::ADDR_PINPWR, 8'h5f);
    rr(usbdc_pkg::ADDR_PINPWR, 8'h47);
    check(8'({pin_sel, out_g, reg_pd, phy_powerdown_signal, pll_pd}), 8'h0f);
    rw(usbdc_pkg::ADDR_PINPWR, 8'h80);
    rr(usbdc_pkg::ADDR_PINPWR, 8'h80);
    check(8'({pin_sel, out_g, reg_pd, phy_powerdown_signal, pll_pd}), 8'h10);
  endtask
  task automatic t_ctrl;
    rw(usbdc_pkg::ADDR_CTRL, 8'hff);
    rr(usbdc_pkg::ADDR_CTRL, 8'h7b);
    check(8'({en, resume, stall, in_g, clk_gate}), 8'h1f);
    @(posedge clk) suspend <= 1'b1;
    rr(usbdc_pkg::ADDR_CTRL, 8'h7f);
    @(posedge clk) suspend <= 1'b0;
    repeat (4) @(posedge clk);
    check(8'(wake), 8'h01);
    rr(usbdc_pkg::ADDR_PINPWR, 8'ha0);
    rw(usbdc_pkg::ADDR_PINPWR, 8'h80);
    rr(usbdc_pkg::ADDR_PINPWR, 8'h80);
    check(8'(wake), 8'h00);
    rw(usbdc_pkg::ADDR_CTRL, 8'h20);
    rr(usbdc_pkg::ADDR_CTRL, 8'h22);
    check(8'({en, resume, stall, in_g, clk_gate}), 8'h00);
  endtask
  task automatic t_flags;
    @(posedge clk) req_seen <= 4'hf;
    @(posedge clk) req_seen <= 4'h0;
    rr(usbdc_pkg::ADDR_STDREQ, 8'h0f);
    rw(usbdc_pkg::ADDR_STDREQ, 8'hfa);
    rr(usbdc_pkg::ADDR_STDREQ, 8'h0a);
    @(posedge clk) {cur_if, cur_alt, cur_ep} <= 6'h2d;
    rr(usbdc_pkg::ADDR_STATE, 8'h2d);
  endtask
  task automatic t_cfg;
    logic [7:0] b [5] = '{8'hc0, 8'h95, 8'h6a, 8'h3f, 8'h1b};
    for (int i = 0; i < 5; i++) begin
      cmd(usbdc_pkg::H_CFG0 + 8'(i), b[i]);
    end
    cmd(usbdc_pkg::H_CMD, 8'h01);
    idle;
    rr(usbdc_pkg::ADDR_CFGSTA, 8'h40);
    check(8'(done), 8'h01);
    for (int i = 0; i < 4; i++) begin
      check(ep_cfg[i], b[i]);
    end
    check({out_type[0], out_type[1], out_type[2], out_type[3]}, b[4]);
  endtask
  task automatic t_irq;
    logic [7:0] ev [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
    rw(usbdc_pkg::ADDR_IRQEN, 8'hff);
    rr(usbdc_pkg::ADDR_IRQEN, 8'hfb);
    foreach (ev[i]) begin
      @(posedge clk) bus_event <= ev[i];
      @(posedge clk) bus_event <= 8'h00;
      rr(usbdc_pkg::ADDR_EVSTA, ev[i]);
      check(8'(irq), 8'h01);
      rw(usbdc_pkg::ADDR_EVSTA, 8'h00);
    end
    @(posedge clk) bus_event <= 8'h40;
    @(posedge clk) bus_event <= 8'h00;
    rw(usbdc_pkg::ADDR_IRQEN, 8'h00);
    rr(usbdc_pkg::ADDR_EVSTA, 8'h40);
    check(8'(irq), 8'h00);
  endtask
  task automatic t_phy;
    rw(usbdc_pkg::ADDR_PINPWR, 8'h82);
    rr(usbdc_pkg::ADDR_PINPWR, 8'h82);
    check(8'(phy_powerdown_signal), 8'h01);
    cmd(usbdc_pkg::H_CMD, 8'h02);
    idle;
    check(8'(phy_powerdown_signal), 8'h00);
    get(usbdc_pkg::H_STAT, v);
    check(v & 8'h04, 8'h04);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_pinpwr;
    t_ctrl;
    t_flags;
    t_cfg;
    t_irq;
    t_phy;
    conclude;
  end
  initial begin
    #1000000;
    err_count++;
    $display("ERROR %0t: run did not finish", $time);
    conclude;
  end
endmodule
`default_nettype wire

// ==== usbdc_device.sv ====
// Device end: USB control, status and endpoint configuration registers
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module usbdc_device (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  usbdc_if.dev                         bus,
  input  wire logic                    i_suspend,
  input  wire logic                    i_pll_rst,
  input  wire logic                    i_dev_rst,
  input  wire logic [3:0]              i_req_seen,
  input  wire logic [1:0]              i_cur_if,
  input  wire logic                    i_cur_alt,
  input  wire logic [2:0]              i_cur_ep,
  input  wire logic [7:0]              i_bus_event,
  output logic                         o_usb_pin_select,
  output logic                         o_out_buffer_guard,
  output logic                         o_in_buffer_guard,
  output logic                         o_regulator_powerdown,
  output logic                         o_phy_powerdown_signal,
  output logic                         o_pll_powerdown,
  output logic                         o_controller_enable,
  output logic                         o_resume_signal,
  output logic                         o_ep0_stall,
  output logic                         o_fullspeed_clock_gate,
  output usbdc_pkg::usbdc_epcfg_s [3:0] o_ep_cfg,
  output logic [3:0][1:0]              o_ep_out_type,
  output logic                         o_cfg_load_done
);
  typedef struct packed {
    logic            pin_sel;
    logic            out_guard;
    logic            reg_pd;
    logic            phy_powerdown_signal;
    logic            pll_pd;
    logic            ctrl_en;
    logic            rwake;
    logic            resume;
    logic            stall;
    logic            in_guard;
    logic            clk_gate;
    logic            susp_d;
    logic            cfg_rdy;
    logic            cfg_done;
    logic [2:0]      cfg_idx;
    logic [7:0]      cfg_last;
    logic [4:0][7:0] cfg;
    logic [7:0]      irq_en;
    logic [7:0]      rdata;
    logic            irq;
  } usbdc_dev_s;
  usbdc_dev_s s_r;
  usbdc_dev_s s_nxt;

  logic [3:0] std_q;
  logic [3:0] std_clr;
  logic [7:0] ev_q;
  logic [7:0] ev_clr;
  logic       wake_q;
  logic       wake_set;
  logic       wake_clr;
  logic       wr_pinpwr;

  assign wr_pinpwr = bus.wr && (bus.addr == usbdc_pkg::ADDR_PINPWR);
  // Falling edge of suspend wakes the processor
  assign wake_set = s_r.susp_d & ~i_suspend;
  assign wake_clr = wr_pinpwr & ~bus.wdata[usbdc_pkg::PP_WAKE];
  // Writing 0 clears a flag, writing 1 leaves it
  assign std_clr = (bus.wr && bus.addr == usbdc_pkg::ADDR_STDREQ) ?
                   ~bus.wdata[3:0] : 4'h0;
  assign ev_clr  = (bus.wr && bus.addr == usbdc_pkg::ADDR_EVSTA) ?
                   ~bus.wdata : 8'h0;

  // Flags: hardware set wins over a same-cycle clear
  usbdc_sticky #(.W(1)) u_wake (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_set    (wake_set),
    .i_clr    (wake_clr),
    .o_q      (wake_q)
  );

  usbdc_sticky #(.W(usbdc_pkg::STDREQ_W)) u_std (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_set    (i_req_seen),
    .i_clr    (std_clr),
    .o_q      (std_q)
  );

  // Reserved event bit never sets a flag
  usbdc_sticky #(.W(8)) u_event (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_set    (i_bus_event & usbdc_pkg::EVENT_MASK),
    .i_clr    (ev_clr),
    .o_q      (ev_q)
  );

  always_comb begin
    s_nxt = s_r;
    // Read data stand one cycle, zero otherwise
    s_nxt.rdata = 8'h00;
    s_nxt.susp_d = i_suspend;
    s_nxt.resume = s_r.rwake & s_r.ctrl_en;
    s_nxt.irq = |(ev_q & s_r.irq_en);
    if (bus.wr) begin
      if (bus.addr == usbdc_pkg::ADDR_PINPWR) begin
        s_nxt.pin_sel   = bus.wdata[usbdc_pkg::PP_PIN];
        s_nxt.out_guard = bus.wdata[usbdc_pkg::PP_OUTG];
        s_nxt.reg_pd    = bus.wdata[usbdc_pkg::PP_REGPD];
        s_nxt.phy_powerdown_signal    = bus.wdata[usbdc_pkg::PP_PHY_POWERDOWN];
        s_nxt.pll_pd    = bus.wdata[usbdc_pkg::PP_PLL_POWERDOWN];
      end else if (bus.addr == usbdc_pkg::ADDR_CTRL) begin
        s_nxt.ctrl_en  = bus.wdata[usbdc_pkg::CT_EN];
        s_nxt.rwake    = bus.wdata[usbdc_pkg::CT_RWAKE];
        s_nxt.stall    = bus.wdata[usbdc_pkg::CT_STALL];
        s_nxt.in_guard = bus.wdata[usbdc_pkg::CT_ING];
        s_nxt.clk_gate = bus.wdata[usbdc_pkg::CT_CLKG];
      end else if (bus.addr == usbdc_pkg::ADDR_CFGDAT) begin
        // A write after a finished load starts a new one
        s_nxt.cfg_last = bus.wdata;
        s_nxt.cfg_rdy  = 1'b0;
        s_nxt.cfg_done = 1'b0;
        if (s_r.cfg_done) begin
          s_nxt.cfg[0] = bus.wdata;
          s_nxt.cfg_idx = 3'h1;
          s_nxt.cfg_rdy = 1'b1;
        end else begin
          s_nxt.cfg[s_r.cfg_idx] = bus.wdata;
          if (s_r.cfg_idx == usbdc_pkg::CFG_LAST) begin
            s_nxt.cfg_idx  = 3'h0;
            s_nxt.cfg_done = 1'b1;
          end else begin
            s_nxt.cfg_idx = s_r.cfg_idx + 3'h1;
            s_nxt.cfg_rdy = 1'b1;
          end
        end
      end else if (bus.addr == usbdc_pkg::ADDR_IRQEN) begin
        s_nxt.irq_en = bus.wdata & usbdc_pkg::EVENT_MASK;
      end
    end
    if (bus.rd) begin
      if (bus.addr == usbdc_pkg::ADDR_PINPWR) begin
        s_nxt.rdata[usbdc_pkg::PP_PIN]   = s_r.pin_sel;
        s_nxt.rdata[usbdc_pkg::PP_OUTG]  = s_r.out_guard;
        s_nxt.rdata[usbdc_pkg::PP_WAKE]  = wake_q;
        s_nxt.rdata[usbdc_pkg::PP_REGPD] = s_r.reg_pd;
        s_nxt.rdata[usbdc_pkg::PP_PHY_POWERDOWN] = s_r.phy_powerdown_signal;
        s_nxt.rdata[usbdc_pkg::PP_PLL_POWERDOWN] = s_r.pll_pd;
      end else if (bus.addr == usbdc_pkg::ADDR_STDREQ) begin
        s_nxt.rdata = {4'h0, std_q};
      end else if (bus.addr == usbdc_pkg::ADDR_CTRL) begin
        s_nxt.rdata[usbdc_pkg::CT_EN]    = s_r.ctrl_en;
        s_nxt.rdata[usbdc_pkg::CT_RWAKE] = s_r.rwake;
        s_nxt.rdata[usbdc_pkg::CT_STALL] = s_r.stall;
        s_nxt.rdata[usbdc_pkg::CT_ING]   = s_r.in_guard;
        // Suspend and reset ready are read live
        s_nxt.rdata[usbdc_pkg::CT_SUSP]  = i_suspend;
        s_nxt.rdata[usbdc_pkg::CT_RRDY]  = ~i_pll_rst & ~i_dev_rst;
        s_nxt.rdata[usbdc_pkg::CT_CLKG]  = s_r.clk_gate;
      end else if (bus.addr == usbdc_pkg::ADDR_STATE) begin
        s_nxt.rdata = {2'h0, i_cur_if, i_cur_alt, i_cur_ep};
      end else if (bus.addr == usbdc_pkg::ADDR_CFGSTA) begin
        s_nxt.rdata[usbdc_pkg::CS_RDY]  = s_r.cfg_rdy;
        s_nxt.rdata[usbdc_pkg::CS_DONE] = s_r.cfg_done;
        // Reading status clears the ready bit
        s_nxt.cfg_rdy = 1'b0;
      end else if (bus.addr == usbdc_pkg::ADDR_CFGDAT) begin
        s_nxt.rdata = s_r.cfg_last;
      end else if (bus.addr == usbdc_pkg::ADDR_IRQEN) begin
        s_nxt.rdata = s_r.irq_en;
      end else if (bus.addr == usbdc_pkg::ADDR_EVSTA) begin
        s_nxt.rdata = ev_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_r         <= '0;
      s_r.pin_sel <= usbdc_pkg::RST_PIN_SEL;
      s_r.irq_en  <= usbdc_pkg::RST_IRQEN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdata = s_r.rdata;
  assign bus.irq   = s_r.irq;
  assign bus.wake  = wake_q;
  assign o_usb_pin_select       = s_r.pin_sel;
  assign o_out_buffer_guard     = s_r.out_guard;
  assign o_in_buffer_guard      = s_r.in_guard;
  assign o_regulator_powerdown  = s_r.reg_pd;
  assign o_phy_powerdown_signal = s_r.phy_powerdown_signal;
  assign o_pll_powerdown        = s_r.pll_pd;
  assign o_controller_enable    = s_r.ctrl_en;
  assign o_resume_signal        = s_r.resume;
  assign o_ep0_stall            = s_r.stall;
  assign o_fullspeed_clock_gate = s_r.clk_gate;
  assign o_cfg_load_done        = s_r.cfg_done;
  assign o_ep_cfg = s_r.cfg[3:0];
  // Index 0 is endpoint 1, held in the top field of the fifth byte
  assign o_ep_out_type = {s_r.cfg[4][1:0], s_r.cfg[4][3:2],
                          s_r.cfg[4][5:4], s_r.cfg[4][7:6]};
endmodule
`default_nettype wire

// ==== usbdc_host.sv ====
// Firmware-side controller: configuration load, PHY power and raw access
`timescale 1ns/100ps
`default_nettype none
module usbdc_host (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  usbdc_if.ctl            bus,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic            o_wake
);
  typedef enum logic [3:0] {
    HS_IDLE, HS_CFG_WR, HS_CFG_HI, HS_CFG_LO, HS_CFG_DONE,
    HS_RMW_RD, HS_RMW_WR, HS_PHY_WAIT, HS_RAW_RD
  } usbdc_hst_e;
  typedef struct packed {
    usbdc_hst_e      st;
    logic            pend;
    logic [7:0]      addr;
    logic [7:0]      wdata;
    logic            wr;
    logic            rd;
    logic [4:0][7:0] cfg;
    logic [2:0]      idx;
    logic [7:0]      raw_addr;
    logic [7:0]      rdbk;
    logic            phy_on;
    logic            phy_ready;
    logic            cfg_done;
    logic [8:0]      cnt;
    logic [7:0]      rdata;
    logic            irq;
    logic            wake;
  } usbdc_hst_s;
  usbdc_hst_s s_r;
  usbdc_hst_s s_nxt;
  logic [7:0] pinpwr_new;

  // Writing 1 to the wake flag leaves it untouched
  always_comb begin
    pinpwr_new = bus.rdata;
    pinpwr_new[usbdc_pkg::PP_WAKE]  = 1'b1;
    pinpwr_new[usbdc_pkg::PP_PHY_POWERDOWN] = ~s_r.phy_on;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.irq = bus.irq;
    s_nxt.wake = bus.wake;
    if (i_rd) begin
      if (i_addr == usbdc_pkg::H_STAT) begin
        s_nxt.rdata = {3'h0, s_r.wake, s_r.irq, s_r.phy_ready,
                       s_r.cfg_done, s_r.st != HS_IDLE};
      end else if (i_addr >= usbdc_pkg::H_CFG0 &&
                   i_addr < usbdc_pkg::H_STAT) begin
        s_nxt.rdata = s_r.cfg[3'(i_addr - usbdc_pkg::H_CFG0)];
      end else if (i_addr == usbdc_pkg::H_ADDR) begin
        s_nxt.rdata = s_r.raw_addr;
      end else if (i_addr == usbdc_pkg::H_RDBK) begin
        s_nxt.rdata = s_r.rdbk;
      end
    end
    if (i_wr) begin
      if (i_addr >= usbdc_pkg::H_CFG0 && i_addr < usbdc_pkg::H_STAT) begin
        s_nxt.cfg[3'(i_addr - usbdc_pkg::H_CFG0)] = i_wdata;
      end else if (i_addr == usbdc_pkg::H_ADDR) begin
        s_nxt.raw_addr = i_wdata;
      end
    end
    case (s_r.st)
      HS_IDLE: begin
        if (i_wr && i_addr == usbdc_pkg::H_DATA) begin
          s_nxt.wr = 1'b1;
          s_nxt.addr = s_r.raw_addr;
          s_nxt.wdata = i_wdata;
        end else if (i_wr && i_addr == usbdc_pkg::H_CMD) begin
          if (i_wdata[usbdc_pkg::HC_CFG]) begin
            s_nxt.idx = 3'h0;
            s_nxt.cfg_done = 1'b0;
            s_nxt.st = HS_CFG_WR;
          end else if (i_wdata[usbdc_pkg::HC_PHYON] ||
                       i_wdata[usbdc_pkg::HC_PHYOFF]) begin
            s_nxt.phy_on = i_wdata[usbdc_pkg::HC_PHYON];
            s_nxt.phy_ready = 1'b0;
            s_nxt.st = HS_RMW_RD;
          end else if (i_wdata[usbdc_pkg::HC_RAWRD]) begin
            s_nxt.st = HS_RAW_RD;
          end
        end
      end
      HS_CFG_WR: begin
        // Exactly five bytes, in endpoint order
        s_nxt.wr = 1'b1;
        s_nxt.addr = usbdc_pkg::ADDR_CFGDAT;
        s_nxt.wdata = s_r.cfg[s_r.idx];
        s_nxt.st = (s_r.idx == usbdc_pkg::CFG_LAST) ? HS_CFG_DONE
                                                    : HS_CFG_HI;
      end
      HS_CFG_HI, HS_CFG_LO, HS_CFG_DONE, HS_RMW_RD, HS_RAW_RD: begin
        if (!s_r.pend) begin
          s_nxt.rd = 1'b1;
          s_nxt.pend = 1'b1;
          if (s_r.st == HS_RMW_RD) begin
            s_nxt.addr = usbdc_pkg::ADDR_PINPWR;
          end else if (s_r.st == HS_RAW_RD) begin
            s_nxt.addr = s_r.raw_addr;
          end else begin
            s_nxt.addr = usbdc_pkg::ADDR_CFGSTA;
          end
        end else if (!s_r.rd) begin
          // Read data stand in the cycle after the strobe
          s_nxt.pend = 1'b0;
          case (s_r.st)
            HS_CFG_HI: begin
              if (bus.rdata[usbdc_pkg::CS_RDY]) begin
                s_nxt.st = HS_CFG_LO;
              end
            end
            HS_CFG_LO: begin
              if (!bus.rdata[usbdc_pkg::CS_RDY]) begin
                s_nxt.idx = s_r.idx + 3'h1;
                s_nxt.st = HS_CFG_WR;
              end
            end
            HS_CFG_DONE: begin
              if (bus.rdata[usbdc_pkg::CS_DONE]) begin
                s_nxt.cfg_done = 1'b1;
                s_nxt.st = HS_IDLE;
              end
            end
            HS_RMW_RD: begin
              s_nxt.wdata = pinpwr_new;
              s_nxt.st = HS_RMW_WR;
            end
            default: begin
              s_nxt.rdbk = bus.rdata;
              s_nxt.st = HS_IDLE;
            end
          endcase
        end
      end
      HS_RMW_WR: begin
        s_nxt.wr = 1'b1;
        s_nxt.addr = usbdc_pkg::ADDR_PINPWR;
        s_nxt.cnt = 9'(usbdc_pkg::PHY_CYC);
        s_nxt.st = s_r.phy_on ? HS_PHY_WAIT : HS_IDLE;
      end
      HS_PHY_WAIT: begin
        // Stabilisation wait after the PHY is enabled
        s_nxt.cnt = s_r.cnt - 9'h1;
        if (s_r.cnt == 9'h1) begin
          s_nxt.phy_ready = 1'b1;
          s_nxt.st = HS_IDLE;
        end
      end
      default: begin
        s_nxt.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.addr  = s_r.addr;
  assign bus.wdata = s_r.wdata;
  assign bus.wr    = s_r.wr;
  assign bus.rd    = s_r.rd;
  assign o_rdata   = s_r.rdata;
  assign o_irq     = s_r.irq;
  assign o_wake    = s_r.wake;
endmodule
`default_nettype wire

// ==== usbdc_if.sv ====
// Register bus between the firmware-side controller and the device block
`timescale 1ns/100ps
`default_nettype none
interface usbdc_if (
  input wire logic i_clk
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic       wake;
  modport dev (input addr, wdata, wr, rd, output rdata, irq, wake);
  modport ctl (output addr, wdata, wr, rd, input rdata, irq, wake);
endinterface
`default_nettype wire

// ==== usbdc_pkg.sv ====
// Constants shared by the USB device control block, its controller and bus
package usbdc_pkg;
  // Device register offsets
  localparam logic [7:0] ADDR_STDREQ = 8'h9d;
  localparam logic [7:0] ADDR_CTRL   = 8'hb1;
  localparam logic [7:0] ADDR_STATE  = 8'hb2;
  localparam logic [7:0] ADDR_CFGSTA = 8'hb3;
  localparam logic [7:0] ADDR_CFGDAT = 8'hb4;
  localparam logic [7:0] ADDR_IRQEN  = 8'hb5;
  localparam logic [7:0] ADDR_EVSTA  = 8'hb9;
  localparam logic [7:0] ADDR_PINPWR = 8'hda;
  // Pin and power control fields
  localparam int PP_PIN   = 7;
  localparam int PP_OUTG  = 6;
  localparam int PP_WAKE  = 5;
  localparam int PP_REGPD = 2;
  localparam int PP_PHY_POWERDOWN = 1;
  localparam int PP_PLL_POWERDOWN = 0;
  localparam logic RST_PIN_SEL = 1'h1;
  // Controller control fields
  localparam int CT_EN    = 6;
  localparam int CT_RWAKE = 5;
  localparam int CT_STALL = 4;
  localparam int CT_ING   = 3;
  localparam int CT_SUSP  = 2;
  localparam int CT_RRDY  = 1;
  localparam int CT_CLKG  = 0;
  // Configuration status fields, then flag widths, event mask, reset values and load length
  localparam int CS_RDY  = 7;
  localparam int CS_DONE = 6;
  localparam int STDREQ_W = 4;
  localparam logic [7:0] RST_IRQEN  = 8'h62;
  localparam logic [7:0] EVENT_MASK = 8'hfb;
  localparam logic [2:0] CFG_LAST   = 3'h4;
  localparam int CFG_BYTES = 5;
  // Transfer types
  typedef enum logic [1:0] {
    XFER_CONTROL = 2'h0,
    XFER_ISO     = 2'h1,
    XFER_BULK    = 2'h2,
    XFER_INTR    = 2'h3
  } usbdc_xfer_e;
  typedef struct packed {
    logic [1:0]  cfg_val;
    logic [1:0]  intf;
    logic [1:0]  alt;
    usbdc_xfer_e in_type;
  } usbdc_epcfg_s;
  // Controller command port
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_CFG0 = 8'h01;
  localparam logic [7:0] H_STAT = 8'h06;
  localparam logic [7:0] H_ADDR = 8'h07;
  localparam logic [7:0] H_DATA = 8'h08;
  localparam logic [7:0] H_RDBK = 8'h09;
  localparam int HC_CFG    = 0;
  localparam int HC_PHYON  = 1;
  localparam int HC_PHYOFF = 2;
  localparam int HC_RAWRD  = 3;
  // PHY stabilisation time
  localparam int CLK_NS     = 20;
  localparam int PHY_WAIT_NS = 5000;
  localparam int PHY_CYC = (PHY_WAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== usbdc_props.sv ====
// Checker on the register bus between controller and device
`timescale 1ns/100ps
`default_nettype none
module usbdc_props (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       wake
);
  typedef struct packed {
    logic pend;
    logic rdy_rd;
    logic en_wr;
    logic pin_wr;
  } usbdc_chk_s;
  usbdc_chk_s st_r;
  usbdc_chk_s st_nxt;
  logic       rd_sta;
  assign rd_sta = rd && (addr == usbdc_pkg::ADDR_CFGSTA);
  // Ready seen high by a read, no write since
  always_comb begin
    st_nxt = st_r;
    st_nxt.pend = rd_sta;
    st_nxt.rdy_rd = (st_r.rdy_rd || (st_r.pend && rdata[7])) && !wr;
    st_nxt.en_wr = st_r.en_wr || (wr && addr == usbdc_pkg::ADDR_IRQEN);
    st_nxt.pin_wr = st_r.pin_wr || (wr && addr == usbdc_pkg::ADDR_PINPWR);
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_rdy_clr;
    rd_sta && st_r.rdy_rd |=> !rdata[7];
  endproperty
  a_rdy_clr: assert property (p_rdy_clr)
    else $error("ready bit not cleared by read");
  property p_std_hi;
    rd && addr == usbdc_pkg::ADDR_STDREQ |=> rdata[7:4] == 4'h0;
  endproperty
  a_std_hi: assert property (p_std_hi)
    else $error("request flags upper bits not zero");
  property p_state_hi;
    rd && addr == usbdc_pkg::ADDR_STATE |=> rdata[7:6] == 2'h0;
  endproperty
  a_state_hi: assert property (p_state_hi)
    else $error("state upper bits not zero");
  property p_cfg_lo;
    rd_sta |=> rdata[5:0] == 6'h00;
  endproperty
  a_cfg_lo: assert property (p_cfg_lo)
    else $error("config status low bits not zero");
  property p_en_b2;
    rd && addr == usbdc_pkg::ADDR_IRQEN |=> !rdata[2];
  endproperty
  a_en_b2: assert property (p_en_b2)
    else $error("enable bit 2 not zero");
  property p_en_rst;
    rd && addr == usbdc_pkg::ADDR_IRQEN && !st_r.en_wr
      |=> rdata == usbdc_pkg::RST_IRQEN;
  endproperty
  a_en_rst: assert property (p_en_rst)
    else $error("enable reset value wrong");
  property p_pin_rst;
    rd && addr == usbdc_pkg::ADDR_PINPWR && !st_r.pin_wr |=> rdata[7];
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin select not USB after reset");
  property p_irq_mask;
    wr && addr == usbdc_pkg::ADDR_IRQEN && wdata == 8'h00 |-> ##3 !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("request stays with all enables off");
  c_done: cover property (rd_sta ##1 rdata[6]);
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(wake));
endmodule
`default_nettype wire

// ==== usbdc_sticky.sv ====
// Sticky flags: hardware set wins over a same-cycle clear
`timescale 1ns/100ps
`default_nettype none
module usbdc_sticky #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] q;
  } usbdc_stk_s;
  usbdc_stk_s s_r;
  usbdc_stk_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.q = (s_r.q & ~i_clr) | i_set;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;
endmodule
`default_nettype wire
